// >>> rtl/rtcpg_top.sv
// power-control sequencer, time keeping and timestamp registers on AXI4-Lite
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module rtcpg_top (
	// clock and reset
	input wire logic                       clock,
	input wire logic                       rst,
	// axi4-lite write
	input wire logic                       s_axi_awvalid,
	output logic                           s_axi_awready,
	input wire logic [rtcpg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic                       s_axi_wvalid,
	output logic                           s_axi_wready,
	input wire logic [31:0]                s_axi_wdata,
	input wire logic [3:0]                 s_axi_wstrb,
	output logic                           s_axi_bvalid,
	input wire logic                       s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	// axi4-lite read
	input wire logic                       s_axi_arvalid,
	output logic                           s_axi_arready,
	input wire logic [rtcpg_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                           s_axi_rvalid,
	input wire logic                       s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// calendar events and inputs
	input wire logic                       second_tick,
	input wire logic                       repeat_tick,
	input wire logic                       pwc_clock_tick,
	input wire logic                       tamper_input,
	input wire logic                       on_backup,
	input wire logic [15:0]                date_low,
	input wire logic [15:0]                date_high,
	// power control and events
	output logic                           clock_pin_out,
	output logic                           clock_pin_oe,
	output logic                           sample_gate,
	output logic                           stability_window,
	output logic                           clock_irq
);
	import rtcpg_pkg::*;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_TSB_DH);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (be[0]) v[7:0] = d[7:0];
		if (be[1]) v[15:8] = d[15:8];
		return v & mask;
	endfunction

	// bcd minutes or seconds, tens in 6:4, ones in 3:0; msb of result is the carry
	function automatic logic [7:0] bcd60_next(input logic [6:0] v);
		if (v[3:0] == 4'h9) begin
			if (v[6:4] == 3'h5) return 8'h80;
			return {1'b0, 3'(v[6:4] + 3'h1), 4'h0};
		end
		return {1'b0, v[6:4], 4'(v[3:0] + 4'h1)};
	endfunction

	function automatic logic [7:0] ps_limit(input logic [1:0] code);
		case (code)
			2'h0: return PS_LIM_1;
			2'h1: return PS_LIM_16;
			2'h2: return PS_LIM_64;
			default: return PS_LIM_256;
		endcase
	endfunction

	// axi state
	logic                aw_q;
	logic                w_q;
	logic [ADDR_W-1:0]   awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic                wr_go;
	logic                rd_go;
	logic [15:0]         rd_mux;
	// registers
	logic [15:0]         ctl1_q;
	logic [15:0]         ctl2_q;
	logic [15:0]         ctl3_q;
	logic [15:0]         time_lo_q;
	logic [15:0]         time_hi_q;
	logic                tamper_prev_q;
	logic                backup_prev_q;
	logic                stat_wr;
	logic [7:0]          sec_nx;
	logic [7:0]          min_nx;
	// sequencer
	rtcpg_seq_e          state_q;
	rtcpg_seq_e          state_d;
	logic                run_prev_q;
	logic                run_en;
	logic                start;
	logic [7:0]          ps_cnt_q;
	logic                ps_tick;
	logic [7:0]          win_cnt_q;
	logic [7:0]          stab_len;
	logic [7:0]          samp_len;
	logic [7:0]          cur_len;
	logic                win_end;
	logic                pin_sel;
	logic                pin_q;
	logic                irq_q;

	rtcpg_stamp_if st_a ();
	rtcpg_stamp_if st_b ();

	rtcpg_stamp u_stamp_a (
		.clock (clock),
		.rst   (rst),
		.st    (st_a.unit)
	);

	rtcpg_stamp u_stamp_b (
		.clock (clock),
		.rst   (rst),
		.st    (st_b.unit)
	);

	// write channel: address and data taken in either order, one response at a time
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;
	assign wr_go         = aw_q && w_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_q     <= 1'b0;
				w_q      <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel: data registered on the edge that takes the address, valid the cycle after
	assign s_axi_arready = !rvalid_q;
	assign rd_go         = s_axi_arvalid && !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_comb begin
		case (s_axi_araddr)
			OFS_CTL1:    rd_mux = ctl1_q;
			OFS_CTL2:    rd_mux = ctl2_q;
			OFS_CTL3:    rd_mux = ctl3_q;
			OFS_STAT:    rd_mux = {11'h000, st_b.flag, st_a.flag, stability_window, sample_gate,
				state_q != SEQ_IDLE};
			OFS_TIME_LO: rd_mux = time_lo_q;
			OFS_TIME_HI: rd_mux = time_hi_q;
			OFS_TSA_TL:  rd_mux = st_a.tl;
			OFS_TSA_TH:  rd_mux = st_a.th;
			OFS_TSA_DL:  rd_mux = st_a.dl;
			OFS_TSA_DH:  rd_mux = st_a.dh;
			OFS_TSB_TL:  rd_mux = st_b.tl;
			OFS_TSB_TH:  rd_mux = st_b.th;
			OFS_TSB_DL:  rd_mux = st_b.dl;
			OFS_TSB_DH:  rd_mux = st_b.dh;
			default:     rd_mux = REG_RESET;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {16'h0000, rd_mux};
			rresp_q  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl1_q <= REG_RESET;
			ctl2_q <= REG_RESET;
			ctl3_q <= REG_RESET;
		end else if (wr_go) begin
			if (awaddr_q == OFS_CTL1) ctl1_q <= merge(ctl1_q, wdata_q, wstrb_q, CTL1_MASK);
			if (awaddr_q == OFS_CTL2) ctl2_q <= merge(ctl2_q, wdata_q, wstrb_q, CTL2_MASK);
			if (awaddr_q == OFS_CTL3) ctl3_q <= merge(ctl3_q, wdata_q, wstrb_q, CTL3_MASK);
		end
	end

	// a function result cannot be part-selected, so the next values get names of their own
	assign sec_nx = bcd60_next(time_lo_q[14:8]);
	assign min_nx = bcd60_next(time_hi_q[6:0]);

	// live time: a software write wins over the second tick of the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			time_lo_q <= REG_RESET;
			time_hi_q <= REG_RESET;
		end else if (wr_go && (awaddr_q == OFS_TIME_LO || awaddr_q == OFS_TIME_HI)) begin
			if (awaddr_q == OFS_TIME_LO) time_lo_q <= merge(time_lo_q, wdata_q, wstrb_q, TIME_LO_MASK);
			if (awaddr_q == OFS_TIME_HI) time_hi_q <= merge(time_hi_q, wdata_q, wstrb_q, TIME_HI_MASK);
		end else if (second_tick && ctl1_q[CTL1_CAL_EN]) begin
			time_lo_q[14:8] <= sec_nx[6:0];
			if (sec_nx[7]) begin
				time_hi_q[6:0] <= min_nx[6:0];
				if (min_nx[7]) begin
					if (time_hi_q[13:8] == 6'h23) time_hi_q[13:8] <= 6'h00;
					else if (time_hi_q[11:8] == 4'h9) time_hi_q[13:8] <= {2'(time_hi_q[13:12] + 2'h1), 4'h0};
					else time_hi_q[11:8] <= 4'(time_hi_q[11:8] + 4'h1);
				end
			end
		end
	end

	// timestamp triggers; inputs are synchronous, so one stage finds the edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tamper_prev_q <= 1'b1;
			backup_prev_q <= 1'b0;
		end else begin
			tamper_prev_q <= tamper_input;
			backup_prev_q <= on_backup;
		end
	end

	assign stat_wr     = wr_go && (awaddr_q == OFS_STAT) && wstrb_q[0];
	assign st_a.trig   = tamper_prev_q && !tamper_input;
	assign st_a.manual = stat_wr && wdata_q[STAT_TSA];
	assign st_a.clear  = stat_wr && !wdata_q[STAT_TSA];
	assign st_a.enable = ctl1_q[CTL1_TSA_EN];
	assign st_b.trig   = !backup_prev_q && on_backup;
	assign st_b.manual = stat_wr && wdata_q[STAT_TSB];
	assign st_b.clear  = stat_wr && !wdata_q[STAT_TSB];
	assign st_b.enable = ctl1_q[CTL1_TSB_EN];
	assign st_a.now_tl = time_lo_q;
	assign st_a.now_th = time_hi_q;
	assign st_a.now_dl = date_low;
	assign st_a.now_dh = date_high;
	assign st_b.now_tl = time_lo_q;
	assign st_b.now_th = time_hi_q;
	assign st_b.now_dl = date_low;
	assign st_b.now_dh = date_high;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= st_a.done || st_b.done;
		end
	end
	assign clock_irq = irq_q;

	// power-control sequencer
	assign run_en   = ctl1_q[CTL1_CAL_EN] && ctl1_q[CTL1_PWC_EN];
	assign stab_len = ctl3_q[CTL3_STAB_LO +: 8];
	assign samp_len = ctl3_q[CTL3_SAMP_LO +: 8];
	// first run on enable; later runs only on the repeat tick
	assign start    = run_en && (state_q == SEQ_IDLE) &&
		(!run_prev_q || (ctl1_q[CTL1_REPEAT] && repeat_tick));
	assign ps_tick  = pwc_clock_tick && (ps_cnt_q == ps_limit(ctl2_q[CTL2_PS_LO +: 2]));
	assign cur_len  = (state_q == SEQ_STAB) ? stab_len : samp_len;
	assign win_end  = ps_tick && (8'(win_cnt_q + 8'h01) == cur_len);

	always_comb begin
		state_d = state_q;
		case (state_q)
			SEQ_IDLE: begin
				if (start) begin
					if (stab_len != LEN_OFF) state_d = SEQ_STAB;
					else if (samp_len != LEN_OFF) state_d = SEQ_SAMP;
				end
			end
			SEQ_STAB: begin
				if (!run_en) state_d = SEQ_IDLE;
				else if (stab_len == STAB_ALWAYS) state_d = SEQ_STAB;
				else if (win_end || stab_len == LEN_OFF)
					state_d = (samp_len != LEN_OFF) ? SEQ_SAMP : SEQ_IDLE;
			end
			SEQ_SAMP: begin
				if (!run_en || win_end || samp_len == LEN_OFF) state_d = SEQ_IDLE;
			end
			default: state_d = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q    <= SEQ_IDLE;
			run_prev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			run_prev_q <= run_en;
		end
	end

	// prescaler restarts with each sequence so the first period is whole
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ps_cnt_q <= 8'h00;
		end else if (state_q == SEQ_IDLE) begin
			ps_cnt_q <= 8'h00;
		end else if (pwc_clock_tick) begin
			ps_cnt_q <= ps_tick ? 8'h00 : 8'(ps_cnt_q + 8'h01);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			win_cnt_q <= 8'h00;
		end else if (state_d != state_q) begin
			win_cnt_q <= 8'h00;
		end else if (ps_tick) begin
			win_cnt_q <= 8'(win_cnt_q + 8'h01);
		end
	end

	assign pin_sel = ctl1_q[CTL1_OE] && (ctl1_q[CTL1_SEL_LO +: 3] == CLOCK_PIN_OUTPUT_SELECT_PWC);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_sel && ((state_q != SEQ_IDLE) == ctl1_q[CTL1_POL]);
		end
	end

	assign clock_pin_out    = pin_q;
	assign clock_pin_oe     = ctl1_q[CTL1_OE];
	assign sample_gate      = (state_q == SEQ_SAMP);
	assign stability_window = (state_q == SEQ_STAB) || (stab_len == STAB_ALWAYS);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_pin_pol;
		(pin_sel && $stable(pin_sel) && $stable(ctl1_q[CTL1_POL]))
			|-> (clock_pin_out == (($past(state_q) != SEQ_IDLE) == ctl1_q[CTL1_POL]));
	endproperty
	a_pin_pol: assert property (p_pin_pol) else $error("power pin polarity wrong");

	property p_pin_sel;
		!pin_sel |=> !clock_pin_out;
	endproperty
	a_pin_sel: assert property (p_pin_sel) else $error("power pin driven while not selected");

	property p_stab_start;
		(start && stab_len != LEN_OFF) |=> (state_q == SEQ_STAB && stability_window && !sample_gate);
	endproperty
	a_stab_start: assert property (p_stab_start) else $error("stability window did not start");

	property p_gate_follows;
		(state_q == SEQ_STAB && run_en && win_end && stab_len != STAB_ALWAYS && samp_len != LEN_OFF)
			|=> sample_gate;
	endproperty
	a_gate_follows: assert property (p_gate_follows) else $error("sample gate missing");

	property p_close;
		(state_q == SEQ_SAMP && win_end) |=> (!sample_gate && state_q == SEQ_IDLE);
	endproperty
	a_close: assert property (p_close) else $error("windows not closed at sample end");

	property p_samp_off;
		(samp_len == LEN_OFF && $stable(samp_len)) |-> !sample_gate;
	endproperty
	a_samp_off: assert property (p_samp_off) else $error("zero sample length opened gate");

	property p_stab_always;
		(stab_len == STAB_ALWAYS) |-> stability_window;
	endproperty
	a_stab_always: assert property (p_stab_always) else $error("stability window not held");

	property p_prescale;
		ps_tick |-> (ps_cnt_q == ((ctl2_q[7:6] == 2'h0) ? 8'h00 : (ctl2_q[7:6] == 2'h1) ? 8'h0F :
			(ctl2_q[7:6] == 2'h2) ? 8'h3F : 8'hFF));
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescaler period wrong");

	property p_tamper;
		(tamper_prev_q && !tamper_input && st_a.enable && !st_a.flag && !st_a.done) |=> ##1 st_a.flag;
	endproperty
	a_tamper: assert property (p_tamper) else $error("tamper edge not stamped");

	c_full_seq: cover property ((state_q == SEQ_STAB) ##[1:600] (state_q == SEQ_SAMP) ##[1:600] (state_q == SEQ_IDLE));
	c_repeat: cover property (start && run_prev_q);
	c_write: cover property (wr_go && awaddr_q == OFS_CTL3);
endmodule

// >>> rtl/rtcpg_pkg.sv
// constants, register map and types for the power-gate and timestamp block
// Functional notes
// - power output polarity from control1 bit 9
// - control and gate outputs; pin needs select
// - stability window starts with control assert
// - sample gate follows end of stability window
// - sample window end closes all, powers down
// - sample length 15:8, stability 7:0
// - window lengths 0 to 255 periods
// - prescaler 1, 16, 64, 256 at 7:6
// - length zero makes window inactive
// - stability FFh keeps window always active
// - tamper falling edge triggers stamp A
// - switch to backup supply triggers stamp B
// - stamp A captures only while enabled
// - capture copies time/date, sets flag, interrupts
// - further events ignored while flag set
// - writing one starts capture, flag later
// - seconds BCD in bits 14:8, rest zero
// - hours 13:8, minutes 6:0 BCD layout
package rtcpg_pkg;
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_CTL1     = 8'h00;
	localparam logic [7:0]  OFS_CTL2     = 8'h04;
	localparam logic [7:0]  OFS_CTL3     = 8'h08;
	localparam logic [7:0]  OFS_STAT     = 8'h0C;
	localparam logic [7:0]  OFS_TIME_LO  = 8'h10;
	localparam logic [7:0]  OFS_TIME_HI  = 8'h14;
	localparam logic [7:0]  OFS_TSA_TL   = 8'h18;
	localparam logic [7:0]  OFS_TSA_TH   = 8'h1C;
	localparam logic [7:0]  OFS_TSA_DL   = 8'h20;
	localparam logic [7:0]  OFS_TSA_DH   = 8'h24;
	localparam logic [7:0]  OFS_TSB_TL   = 8'h28;
	localparam logic [7:0]  OFS_TSB_TH   = 8'h2C;
	localparam logic [7:0]  OFS_TSB_DL   = 8'h30;
	localparam logic [7:0]  OFS_TSB_DH   = 8'h34;
	localparam int          CTL1_TSA_EN  = 0;
	localparam int          CTL1_REPEAT  = 1;
	localparam int          CTL1_TSB_EN  = 2;
	localparam int          CTL1_SEL_LO  = 4;
	localparam int          CTL1_OE      = 8;
	localparam int          CTL1_POL     = 9;
	localparam int          CTL1_PWC_EN  = 10;
	localparam int          CTL1_CAL_EN  = 15;
	localparam int          CTL2_PS_LO   = 6;
	localparam int          CTL3_SAMP_LO = 8;
	localparam int          CTL3_STAB_LO = 0;
	localparam int          STAT_CTL     = 0;
	localparam int          STAT_GATE    = 1;
	localparam int          STAT_STAB    = 2;
	localparam int          STAT_TSA     = 3;
	localparam int          STAT_TSB     = 4;
	localparam logic [15:0] CTL1_MASK    = 16'h8777;
	localparam logic [15:0] CTL2_MASK    = 16'h00C0;
	localparam logic [15:0] CTL3_MASK    = 16'hFFFF;
	localparam logic [15:0] TIME_LO_MASK = 16'h7F00;
	localparam logic [15:0] TIME_HI_MASK = 16'h3F7F;
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [2:0]  CLOCK_PIN_OUTPUT_SELECT_PWC   = 3'h3;
	localparam logic [7:0]  LEN_OFF      = 8'h00;
	localparam logic [7:0]  STAB_ALWAYS  = 8'hFF;
	localparam logic [7:0]  PS_LIM_1     = 8'h00;
	localparam logic [7:0]  PS_LIM_16    = 8'h0F;
	localparam logic [7:0]  PS_LIM_64    = 8'h3F;
	localparam logic [7:0]  PS_LIM_256   = 8'hFF;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_STAB = 3'b010,
		SEQ_SAMP = 3'b100
	} rtcpg_seq_e;
endpackage

// >>> rtl/rtcpg_stamp_if.sv
// carrier between the register block and one timestamp unit
`timescale 1ns/1ps
interface rtcpg_stamp_if;
	logic        trig;
	logic        manual;
	logic        clear;
	logic        enable;
	logic [15:0] now_tl;
	logic [15:0] now_th;
	logic [15:0] now_dl;
	logic [15:0] now_dh;
	logic        flag;
	logic        done;
	logic [15:0] tl;
	logic [15:0] th;
	logic [15:0] dl;
	logic [15:0] dh;
	modport owner (output trig, manual, clear, enable, now_tl, now_th, now_dl, now_dh,
		input flag, done, tl, th, dl, dh);
	modport unit (input trig, manual, clear, enable, now_tl, now_th, now_dl, now_dh,
		output flag, done, tl, th, dl, dh);
endinterface

// >>> rtl/rtcpg_stamp.sv
// one timestamp capture unit: time and date copy plus event flag
`timescale 1ns/1ps
module rtcpg_stamp (
	// clock and reset
	input wire logic     clock,
	input wire logic     rst,
	// owner side
	rtcpg_stamp_if.unit  st
);
	import rtcpg_pkg::*;

	logic        pend_q;
	logic        flag_q;
	logic [15:0] tl_q;
	logic [15:0] th_q;
	logic [15:0] dl_q;
	logic [15:0] dh_q;

	// a request is only taken while enabled and no unread stamp is held
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= st.enable && !flag_q && !pend_q && (st.trig || st.manual);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tl_q <= REG_RESET;
			th_q <= REG_RESET;
			dl_q <= REG_RESET;
			dh_q <= REG_RESET;
		end else if (pend_q) begin
			tl_q <= st.now_tl;
			th_q <= st.now_th;
			dl_q <= st.now_dl;
			dh_q <= st.now_dh;
		end
	end

	// set wins over a clear arriving in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (pend_q) begin
			flag_q <= 1'b1;
		end else if (st.clear) begin
			flag_q <= 1'b0;
		end
	end

	assign st.flag = flag_q;
	assign st.done = pend_q;
	assign st.tl   = tl_q;
	assign st.th   = th_q;
	assign st.dl   = dl_q;
	assign st.dh   = dh_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_capture;
		(st.enable && !flag_q && !pend_q && (st.trig || st.manual))
			|=> ##1 (flag_q && tl_q == $past(st.now_tl) && dh_q == $past(st.now_dh));
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not copy and flag");

	property p_hold;
		flag_q |=> ($stable(tl_q) && $stable(dl_q));
	endproperty
	a_hold: assert property (p_hold) else $error("stamp changed while flag set");

	property p_disabled;
		(!st.enable && !pend_q) |=> !pend_q;
	endproperty
	a_disabled: assert property (p_disabled) else $error("capture while disabled");

	c_capture: cover property (pend_q ##1 flag_q);
endmodule

// >>> test/rtcpg_dev_model.sv
// far-side device model: powered from the pin, samples wake events under the gate
`timescale 1ns/1ps
module rtcpg_dev_model #(parameter int SETTLE = 2) (
	// pin, gate and result
	input wire logic clock,
	input wire logic pin,
	input wire logic gate,
	output int       wakes
);
	int up = 0;
	// samples taken before the supply settles are junk, so only late ones count
	always @(posedge clock)
		up <= (pin === 1'b1) ? up + 1 : 0;
	always @(posedge clock)
		wakes <= wakes + int'(gate === 1'b1 && up > SETTLE);
	initial wakes = 0;
endmodule

// >>> test/test_rtc_power_gate_and_timestamp.sv
// self-checking bench for the power-gate and timestamp block
`timescale 1ns/1ps
module test_rtc_power_gate_and_timestamp;
	import rtcpg_pkg::*;
	logic        clock, rst, tamper, backup, awv, wv, bre, arv, rre, tick_s, tick_r, tick_p;
	logic        awrdy, wrdy, bv, arrdy, rv, pin, oe, gate, stab, irq;
	logic [7:0]  adr;
	logic [31:0] wd, rdw;
	logic [15:0] dl, dh, rdat;
	logic [1:0]  resp, br, rr;
	wire  [3:0]  obs = {irq, stab, gate, pin};
	int          err_count = 0, checked = 0, wakes;
	rtcpg_top uut (.clock(clock), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(adr),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_araddr(adr),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdw), .s_axi_rresp(rr), .second_tick(tick_s),
		.repeat_tick(tick_r), .pwc_clock_tick(tick_p), .tamper_input(tamper), .on_backup(backup),
		.date_low(dl), .date_high(dh), .clock_pin_out(pin), .clock_pin_oe(oe), .sample_gate(gate),
		.stability_window(stab), .clock_irq(irq));
	rtcpg_dev_model dev (.clock(clock), .pin(pin), .gate(gate), .wakes(wakes));
	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	task automatic stop_test;
		$display("mismatches %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one shared address: only one channel of the pair is offered at a time
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		logic ta, tw, tr, b;
		@(posedge clock);
		awv <= w;
		wv <= w;
		bre <= w;
		arv <= !w;
		rre <= !w;
		adr <= a;
		wd <= {16'h0000, d};
		for (int n = 0; n < 50; n++) begin
			@(negedge clock);
			ta = awv && awrdy;
			tw = wv && wrdy;
			tr = arv && arrdy;
			b = w ? bv && bre : rv && rre;
			rdat = rdw[15:0];
			resp = w ? br : rr;
			@(posedge clock);
			awv <= awv && !ta;
			wv <= wv && !tw;
			arv <= arv && !tr;
			if (b) begin
				bre <= 0;
				rre <= 0;
				return;
			end
		end
		err_count++;
		stop_test;
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		bus(0, a, 16'h0000);
		chk(rdat, e);
	endtask
	task automatic wt(input int i, input logic v, output int n);
		for (n = 1; n < 3000; n++) begin
			@(negedge clock);
			if (obs[i] === v) begin
				@(posedge clock);
				return;
			end
		end
		err_count++;
		stop_test;
	endtask
	task automatic run(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] c3, output int n);
		bus(1, 8'h00, 16'h0000);
		bus(1, 8'h04, c2);
		bus(1, 8'h08, c3);
		bus(1, 8'h00, c1);
		wt(0, 1, n);
		chk({15'h0000, stab}, {15'h0000, c3[7:0] != 8'h00});
		wt(1, 1, n);
		wt(1, 0, n);
		repeat (2) @(posedge clock);
		chk({14'h0000, pin, gate}, 16'h0000);
	endtask
	task automatic s_regs;
		rc(8'h00, REG_RESET);
		bus(0, 8'h3C, 16'h0000);
		chk({14'h0000, resp}, {14'h0000, RESP_SLVERR});
		bus(1, 8'h10, 16'hFFFF);
		rc(8'h10, 16'h7F00);
		bus(1, 8'h14, 16'hFFFF);
		rc(8'h14, 16'h3F7F);
		bus(1, 8'h3C, 16'h0000);
		chk({14'h0000, resp}, {14'h0000, RESP_SLVERR});
		bus(1, 8'h14, 16'h2359);
		bus(1, 8'h10, 16'h5900);
		bus(1, 8'h00, 16'h8000);
		tick_s <= 1;
		@(posedge clock);
		tick_s <= 0;
		rc(8'h10, 16'h0000);
		rc(8'h14, 16'h0000);
		bus(1, 8'h00, 16'h0000);
	endtask
	// ticks every cycle, so one undivided period is one clock
	task automatic s_pwc;
		int n, e;
		run(16'h8730, 16'h0000, 16'h0304, n);
		chk({15'h0000, n >= 2 && n <= 4}, 16'h0001);
		chk({15'h0000, wakes > 0}, 16'h0001);
		run(16'h8732, 16'h0000, 16'h0102, n);
		tick_r <= 1;
		@(posedge clock);
		tick_r <= 0;
		wt(0, 1, n);
		chk({15'h0000, n <= 3}, 16'h0001);
		for (int p = 1; p < 4; p++) begin
			e = 8 << (2 * p);
			run(16'h8730, 16'(p << 6), 16'h0200, n);
			chk({15'h0000, n >= e - 3 && n <= e + 2}, 16'h0001);
		end
		bus(1, 8'h00, 16'h0000);
		bus(1, 8'h08, 16'h00FF);
		repeat (3) @(posedge clock);
		chk({15'h0000, stab}, 16'h0001);
		bus(1, 8'h08, 16'h0000);
		bus(1, 8'h00, 16'h0130);
		repeat (3) @(posedge clock);
		chk({14'h0000, oe, pin}, 16'h0003);
	endtask
	task automatic s_stamp;
		int n;
		bus(1, 8'h10, 16'h5900);
		bus(1, 8'h00, 16'h0001);
		tamper <= 0;
		wt(3, 1, n);
		rc(8'h0C, 16'h0008);
		rc(8'h20, 16'h1234);
		rc(8'h24, 16'h0001);
		tamper <= 1;
		bus(1, 8'h10, 16'h0100);
		tamper <= 0;
		repeat (4) @(posedge clock);
		rc(8'h18, 16'h5900);
		bus(1, 8'h0C, 16'h0000);
		bus(1, 8'h0C, 16'h0008);
		wt(3, 1, n);
		rc(8'h18, 16'h0100);
		tamper <= 1;
		bus(1, 8'h0C, 16'h0000);
		bus(1, 8'h00, 16'h0004);
		tamper <= 0;
		backup <= 1;
		wt(3, 1, n);
		rc(8'h0C, 16'h0010);
	endtask
	initial begin
		{awv, wv, bre, arv, rre, tick_s, tick_r, backup, adr, wd} = 48'h0;
		{rst, tick_p, tamper} = 3'h7;
		{dl, dh} = 32'h1234_0001;
		repeat (4) @(posedge clock);
		rst <= 0;
		s_regs;
		s_pwc;
		s_stamp;
		stop_test;
	end
endmodule
